// *** hw/cidr_pkg.sv ***
// Constants for the indexed configuration register file
package cidr_pkg;
   // ==========================================================
   // Global indices
   localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
   localparam logic [7:0] IDX_RUN_SEL = 8'h03;
   localparam logic [7:0] IDX_LDN = 8'h07;
   localparam logic [7:0] IDX_PWR_CTRL = 8'h22;
   localparam logic [7:0] IDX_GLOBAL_TOP = 8'h2F;
   // ==========================================================
   // Per-device indices
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_BASE_LO = 8'h61;
   localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
   localparam logic [7:0] IDX_SLEEP_WAKE = 8'hF0;
   localparam logic [7:0] IDX_WDT_UNIT = 8'hF1;
   localparam logic [7:0] IDX_WATCHDOG_TIMEOUT_VALUE = 8'hF2;
   localparam logic [7:0] IDX_WDT_SETUP = 8'hF3;
   localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'hF4;
   localparam logic [7:0] IDX_PIN_GRP1 = 8'hF6;
   localparam logic [7:0] IDX_PIN_GRP5 = 8'hF9;
   localparam logic [7:0] IDX_PIN_GRP6 = 8'hFA;
   localparam logic [7:0] IDX_SOFTPWR_LO = 8'hB0;
   localparam logic [7:0] IDX_SOFTPWR_HI = 8'hB3;
   localparam logic [7:0] LDN_AUX = 8'h08;
   localparam logic [7:0] LDN_PM = 8'h0A;
   // ==========================================================
   // Reset values and field layout
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_RUN_SEL = 8'h03;
   localparam logic [2:0] RST_POR_SYNC = 3'h0;
   localparam logic [7:0] RUN_SEL_MASK = 8'h83;
   localparam int RUN_EN_BIT = 7;
   localparam logic [7:0] RUN_LOC_0 = 8'hE0;
   localparam logic [7:0] RUN_LOC_1 = 8'hE2;
   localparam logic [7:0] RUN_LOC_2 = 8'hE4;
   localparam int SOFT_RST_BIT = 0;
   localparam logic [7:0] PWR_CTRL_MASK = 8'h19;
   localparam int PWR_VTR_BIT = 5;
   localparam logic [7:0] WATCHDOG_CONTROL_RW_MASK = 8'hFC;
   localparam int WDT_FORCE_BIT = 0;
   localparam int WDT_STATUS_BIT = 1;
   // ==========================================================
   // Battery-backed auxiliary registers
   localparam int VBAT_COUNT = 16;
   localparam logic [7:0] VBAT_IDX [VBAT_COUNT] = '{
      8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hE1, 8'hE2, 8'hE3, 8'hE4,
      8'hE5, 8'hE6, 8'hE7, 8'hEF, 8'hF0, 8'hF6, 8'hF9, 8'hFA};
   localparam logic [7:0] VBAT_RST [VBAT_COUNT] = '{
      8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01,
      8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
endpackage

// *** hw/cidr_regfile.sv ***
// Indexed configuration register file with index and data ports
`timescale 1ns/1ps
module cidr_regfile
   import cidr_pkg::*;
(
   input wire logic mclk, // 10 MHz clock
   input wire logic srst, // Hard reset, sync, high
   input wire logic vccPor, // Main supply POR pin
   input wire logic vtrPor, // Standby supply POR pin
   input wire logic vbatPor, // Battery POR pin
   input wire logic cfgMode, // Configuration mode active
   input wire logic hostWr, // Write strobe, one cycle
   input wire logic hostRd, // Read strobe, one cycle
   input wire logic portSel, // 0 index port, 1 data port
   input wire logic [7:0] hostWrData, // Write data
   input wire logic wdtStatus, // Watchdog timeout status
   input wire logic sciEvent, // Power event request
   output logic [7:0] hostRdData, // Read data
   output logic [7:0] ldnSel, // Current logical device
   output logic actAux, // Aux device activate
   output logic actPm, // Power device activate
   output logic [15:0] pmBase, // Power event block base
   output logic [7:0] pmIrqSel, // Power device irq select
   output logic [7:0] pmSleepWake, // Sleep/wake setup
   output logic runAccessEn, // Run-mode access open
   output logic [7:0] runSelIndex, // Run-mode location index
   output logic softResetPulse, // Soft reset strobe
   output logic [7:0] globalPowerControl, // Block power enables
   output logic [7:0] wdtUnits, // Watchdog time unit
   output logic [7:0] wdtVal, // Watchdog timeout value
   output logic [7:0] wdtSetup, // Watchdog setup
   output logic [7:0] wdtCtrl, // Watchdog control, stored bits
   output logic wdtForce, // Watchdog force strobe
   output logic sciOut // System control interrupt
);
   // ==========================================================
   // Power-on reset synchronisers
   logic [2:0] porMeta;
   logic [2:0] porSync;
   // No reset: a POR raised during hard reset must still land
   always_ff @(posedge mclk) begin
      porMeta <= {vbatPor, vtrPor, vccPor};
      porSync <= porMeta;
   end

   wire vccPorS = porSync[0];
   wire vtrPorS = porSync[1];
   wire vbatPorS = porSync[2];
   wire hardRst = srst | vccPorS;
   wire vtrRst = hardRst | vtrPorS;

   // ==========================================================
   // Access decode
   logic [7:0] hostIndex;
   logic [7:0] runSel;

   wire isGlobal = hostIndex <= IDX_GLOBAL_TOP;
   wire isSoftPwr = (hostIndex >= IDX_SOFTPWR_LO) &&
                    (hostIndex <= IDX_SOFTPWR_HI);
   wire inRunSet = isSoftPwr || (hostIndex == IDX_WATCHDOG_CONTROL) ||
                   (hostIndex == IDX_PIN_GRP1) ||
                   (hostIndex == IDX_PIN_GRP5) ||
                   (hostIndex == IDX_PIN_GRP6) ||
                   (hostIndex == runSelIndex);
   wire runOk = !cfgMode && runAccessEn && inRunSet;
   wire accessOk = cfgMode || runOk;
   wire auxSel = (cfgMode && ldnSel == LDN_AUX) || runOk;
   wire pmSel = cfgMode && ldnSel == LDN_PM;
   wire idxWr = hostWr && !portSel;
   wire dataWr = hostWr && portSel && accessOk;
   wire dataRd = hostRd && portSel;
   wire gWr = dataWr && cfgMode && isGlobal;
   wire auxWr = dataWr && auxSel && !isGlobal;
   wire pmWr = dataWr && pmSel && !isGlobal;

   wire wrCfgCtrl = gWr && hostIndex == IDX_CFG_CTRL;
   wire wrRunSel = gWr && hostIndex == IDX_RUN_SEL;
   wire wrLdn = gWr && hostIndex == IDX_LDN;
   wire wrPwr = gWr && hostIndex == IDX_PWR_CTRL;
   wire wrActAux = auxWr && hostIndex == IDX_ACTIVATE;
   wire wrActPm = pmWr && hostIndex == IDX_ACTIVATE;
   wire wrBaseHi = pmWr && hostIndex == IDX_BASE_HI;
   wire wrBaseLo = pmWr && hostIndex == IDX_BASE_LO;
   wire wrIrq = pmWr && hostIndex == IDX_IRQ_SEL;
   wire wrSleep = pmWr && hostIndex == IDX_SLEEP_WAKE;
   wire wrWdtUnit = auxWr && hostIndex == IDX_WDT_UNIT;
   wire wrWdtVal = auxWr && hostIndex == IDX_WATCHDOG_TIMEOUT_VALUE;
   wire wrWdtSetup = auxWr && hostIndex == IDX_WDT_SETUP;
   wire wrWdtCtrl = auxWr && hostIndex == IDX_WATCHDOG_CONTROL;

   // Run-mode location from the low select bits
   assign runAccessEn = runSel[RUN_EN_BIT];
   assign runSelIndex = runSel[1] ? RUN_LOC_2 :
                        runSel[0] ? RUN_LOC_1 : RUN_LOC_0;

   // ==========================================================
   // Index port and global registers
   always_ff @(posedge mclk) begin
      if (hardRst) begin
         hostIndex <= RST_ZERO;
      end else if (idxWr) begin
         hostIndex <= hostWrData;
      end
   end

   always_ff @(posedge mclk) begin
      if (hardRst) begin
         softResetPulse <= 1'b0;
      end else begin
         softResetPulse <= wrCfgCtrl && hostWrData[SOFT_RST_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (hardRst) begin
         runSel <= RST_RUN_SEL;
      end else if (wrRunSel) begin
         runSel <= hostWrData & RUN_SEL_MASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (hardRst) begin
         ldnSel <= RST_ZERO;
      end else if (wrLdn) begin
         ldnSel <= hostWrData;
      end
   end

   // Bits other than the standby one follow hard reset
   logic [4:0] pwrLow;
   logic pwrStandby;
   assign globalPowerControl = {2'h0, pwrStandby, pwrLow};

   always_ff @(posedge mclk) begin
      if (hardRst) begin
         pwrLow <= RST_ZERO[4:0];
      end else if (wrPwr) begin
         pwrLow <= hostWrData[4:0] & PWR_CTRL_MASK[4:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (vtrPorS) begin
         pwrStandby <= 1'b0;
      end else if (wrPwr) begin
         pwrStandby <= hostWrData[PWR_VTR_BIT];
      end
   end

   // ==========================================================
   // Soft-resettable device registers
   always_ff @(posedge mclk) begin
      if (vtrRst || softResetPulse) begin
         actAux <= 1'b0;
         actPm <= 1'b0;
         pmBase <= {RST_ZERO, RST_ZERO};
      end else begin
         if (wrActAux) begin
            actAux <= hostWrData[0];
         end
         if (wrActPm) begin
            actPm <= hostWrData[0];
         end
         if (wrBaseHi) begin
            pmBase[15:8] <= hostWrData;
         end
         if (wrBaseLo) begin
            pmBase[7:0] <= hostWrData;
         end
      end
   end

   // ==========================================================
   // Watchdog registers, standby and hard reset, no soft reset
   always_ff @(posedge mclk) begin
      if (vtrRst) begin
         wdtUnits <= RST_ZERO;
         wdtVal <= RST_ZERO;
         wdtSetup <= RST_ZERO;
         wdtCtrl <= RST_ZERO;
      end else begin
         if (wrWdtUnit) begin
            wdtUnits <= hostWrData;
         end
         if (wrWdtVal) begin
            wdtVal <= hostWrData;
         end
         if (wrWdtSetup) begin
            wdtSetup <= hostWrData;
         end
         if (wrWdtCtrl) begin
            wdtCtrl <= hostWrData & WATCHDOG_CONTROL_RW_MASK;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (vtrRst) begin
         wdtForce <= 1'b0;
      end else begin
         wdtForce <= wrWdtCtrl && hostWrData[WDT_FORCE_BIT];
      end
   end

   // ==========================================================
   // Battery-backed registers
   always_ff @(posedge mclk) begin
      if (vbatPorS) begin
         pmIrqSel <= RST_ZERO;
         pmSleepWake <= RST_ZERO;
      end else begin
         if (wrIrq) begin
            pmIrqSel <= hostWrData;
         end
         if (wrSleep) begin
            pmSleepWake <= hostWrData;
         end
      end
   end

   logic [7:0] vbatReg [VBAT_COUNT];
   logic [VBAT_COUNT-1:0] vbatHit;
   genvar gi;
   generate
      for (gi = 0; gi < VBAT_COUNT; gi++) begin : gVbat
         assign vbatHit[gi] = hostIndex == VBAT_IDX[gi];
         always_ff @(posedge mclk) begin
            if (vbatPorS) begin
               vbatReg[gi] <= VBAT_RST[gi];
            end else if (auxWr && vbatHit[gi]) begin
               vbatReg[gi] <= hostWrData;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read selection
   logic [7:0] rdMux;
   logic [7:0] vbatRd;
   always_comb begin
      vbatRd = RST_ZERO;
      for (int i = 0; i < VBAT_COUNT; i++) begin
         if (vbatHit[i]) begin
            vbatRd = vbatReg[i];
         end
      end
   end

   always_comb begin
      rdMux = RST_ZERO;
      if (!accessOk) begin
         rdMux = RST_ZERO;
      end else if (isGlobal) begin
         if (!cfgMode) begin
            rdMux = RST_ZERO;
         end else if (hostIndex == IDX_RUN_SEL) begin
            rdMux = runSel;
         end else if (hostIndex == IDX_LDN) begin
            rdMux = ldnSel;
         end else if (hostIndex == IDX_PWR_CTRL) begin
            rdMux = globalPowerControl;
         end
      end else if (auxSel) begin
         if (hostIndex == IDX_ACTIVATE) begin
            rdMux = {7'h00, actAux};
         end else if (hostIndex == IDX_WDT_UNIT) begin
            rdMux = wdtUnits;
         end else if (hostIndex == IDX_WATCHDOG_TIMEOUT_VALUE) begin
            rdMux = wdtVal;
         end else if (hostIndex == IDX_WDT_SETUP) begin
            rdMux = wdtSetup;
         end else if (hostIndex == IDX_WATCHDOG_CONTROL) begin
            rdMux = {wdtCtrl[7:2], wdtStatus, 1'b0};
         end else begin
            rdMux = vbatRd;
         end
      end else if (pmSel) begin
         if (hostIndex == IDX_ACTIVATE) begin
            rdMux = {7'h00, actPm};
         end else if (hostIndex == IDX_BASE_HI) begin
            rdMux = pmBase[15:8];
         end else if (hostIndex == IDX_BASE_LO) begin
            rdMux = pmBase[7:0];
         end else if (hostIndex == IDX_IRQ_SEL) begin
            rdMux = pmIrqSel;
         end else if (hostIndex == IDX_SLEEP_WAKE) begin
            rdMux = pmSleepWake;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (hardRst) begin
         hostRdData <= RST_ZERO;
      end else if (dataRd) begin
         hostRdData <= rdMux;
      end else if (hostRd) begin
         hostRdData <= hostIndex;
      end
   end

   // Interrupt passes whatever the activate bit holds
   always_ff @(posedge mclk) begin
      if (hardRst) begin
         sciOut <= 1'b0;
      end else begin
         sciOut <= sciEvent;
      end
   end

   // ==========================================================
   // Checks
   chk_global_block: assert property (
      @(posedge mclk) disable iff (srst)
      (hostWr && portSel && !cfgMode && hostIndex == IDX_LDN)
      |=> ldnSel == $past(ldnSel))
      else $error("logical device changed outside config mode");

   chk_soft_self_clear: assert property (
      @(posedge mclk) disable iff (srst)
      (wrCfgCtrl && hostWrData[0] && !vccPorS)
      |=> softResetPulse ##1 !actPm && !actAux && pmBase == 16'h0000)
      else $error("soft reset did not clear device registers");

   chk_soft_pulse_once: assert property (
      @(posedge mclk) disable iff (srst)
      softResetPulse && !wrCfgCtrl |=> !softResetPulse)
      else $error("soft reset strobe did not clear itself");

   chk_ldn_select: assert property (
      @(posedge mclk) disable iff (srst)
      wrLdn && !vccPorS |=> ldnSel == $past(hostWrData))
      else $error("logical device select not taken");

   chk_act_isolated: assert property (
      @(posedge mclk) disable iff (srst)
      (wrActAux && !vtrRst && !softResetPulse)
      |=> actPm == $past(actPm) && actAux == $past(hostWrData[0]))
      else $error("activate write leaked to other device");

   chk_base_high: assert property (
      @(posedge mclk) disable iff (srst)
      (wrBaseHi && !vtrRst && !softResetPulse)
      |=> pmBase[15:8] == $past(hostWrData) &&
          pmBase[7:0] == $past(pmBase[7:0]))
      else $error("base high byte write wrong");

   chk_sci_ungated: assert property (
      @(posedge mclk) disable iff (srst)
      sciEvent && !vccPorS && !actPm |=> sciOut)
      else $error("interrupt gated by activate");

   chk_pwr_standby: assert property (
      @(posedge mclk) disable iff (srst)
      vccPorS && !vtrPorS && !wrPwr
      |=> $stable(globalPowerControl[PWR_VTR_BIT]))
      else $error("power bit 5 reset by wrong source");

   chk_vbat_hold: assert property (
      @(posedge mclk) disable iff (srst)
      vtrPorS && !vbatPorS && !wrIrq |=> $stable(pmIrqSel))
      else $error("battery register reset by standby POR");

   chk_unimpl_zero: assert property (
      @(posedge mclk) disable iff (srst)
      dataRd && cfgMode && hostIndex == 8'h01 && !vccPorS
      |=> hostRdData == 8'h00)
      else $error("unimplemented register read nonzero");

   chk_run_denied: assert property (
      @(posedge mclk) disable iff (srst)
      dataRd && !cfgMode && !runAccessEn && !vccPorS
      |=> hostRdData == 8'h00)
      else $error("run-mode read allowed while disabled");

   chk_run_location: assert property (
      @(posedge mclk) disable iff (srst)
      runSel[1:0] == 2'b01 |-> runSelIndex == 8'hE2)
      else $error("run-mode location decode wrong");

   chk_wdt_mixed: assert property (
      @(posedge mclk) disable iff (srst)
      dataRd && auxSel && hostIndex == IDX_WATCHDOG_CONTROL && accessOk &&
      !vccPorS |=> hostRdData[0] == 1'b0 &&
      hostRdData[1] == $past(wdtStatus))
      else $error("watchdog control access types wrong");

   chk_soft_keeps: assert property (
      @(posedge mclk) disable iff (srst)
      softResetPulse && !vtrRst && !wrWdtVal |=> $stable(wdtVal))
      else $error("soft reset touched watchdog value");

   cov_soft_reset: cover property (
      @(posedge mclk) disable iff (srst) softResetPulse);
   cov_run_access: cover property (
      @(posedge mclk) disable iff (srst) dataWr && runOk);
   cov_ldn_pm: cover property (
      @(posedge mclk) disable iff (srst) wrLdn ##[1:20] wrBaseLo);
   cov_sci: cover property (
      @(posedge mclk) disable iff (srst) sciOut && !actPm);
endmodule

// *** testbench/cidr_host_model.sv ***
// Host model driving the index and data ports of the register file
`timescale 1ns/1ps
module cidr_host_model (
   input wire logic mclk, // 10 MHz clock
   input wire logic [7:0] hostRdData, // Read data from the block
   output logic hostWr, // Write strobe
   output logic hostRd, // Read strobe
   output logic portSel, // 0 index port, 1 data port
   output logic [7:0] hostWrData // Write data
);
   initial begin
      hostWr = 1'b0;
      hostRd = 1'b0;
      portSel = 1'b0;
      hostWrData = 8'h5A;
   end

   // =========================================================
   // Index phase, then data phase
   task automatic set_index(input logic [7:0] idx);
      @(posedge mclk) #1;
      hostRd = 1'b0;
      hostWr = 1'b1;
      portSel = 1'b0;
      hostWrData = idx;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      set_index(idx);
      @(posedge mclk) #1;
      portSel = 1'b1;
      hostWrData = d;
      @(posedge mclk) #1;
      hostWr = 1'b0;
      hostWrData = ~d;
   endtask

   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      set_index(idx);
      @(posedge mclk) #1;
      hostWr = 1'b0;
      hostWrData = ~idx;
      hostRd = 1'b1;
      portSel = 1'b1;
      @(posedge mclk) #1;
      hostRd = 1'b0;
      @(posedge mclk) #1;
      d = hostRdData;
   endtask
endmodule

// *** testbench/test_config_index_data_register_file.sv ***
// Self-checking bench for the indexed configuration register file
`timescale 1ns/1ps
module test_config_index_data_register_file;
   import cidr_pkg::*;
   logic mclk, srst, vccPor, vtrPor, vbatPor, cfgMode, hostWr, hostRd;
   logic portSel, wdtStatus, sciEvent, actAux, actPm, runAccessEn;
   logic softResetPulse, wdtForce, sciOut;
   logic [7:0] hostWrData, hostRdData, ldnSel, pmIrqSel, pmSleepWake;
   logic [7:0] runSelIndex, globalPowerControl, wdtUnits, wdtVal;
   logic [7:0] wdtSetup, wdtCtrl, d, r, u, q;
   logic [15:0] pmBase;
   int nFail, checkCount;
   logic [7:0] rwIdx [12] = '{8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6,
      8'hE7, 8'hEF, 8'hF0, 8'hF1, 8'hF2, 8'hF3};
   logic [7:0] batIdx [7] = '{8'hE1, 8'hE4, 8'hE5, 8'hE7, 8'hEF, 8'hF6,
      8'hFA};
   logic [7:0] batVal [7] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00,
      8'h00};
   logic [7:0] nilIdx [8] = '{8'h00, 8'h01, 8'h08, 8'h15, 8'h1F, 8'h25,
      8'h2A, 8'h50};

   cidr_regfile i_cidr_regfile (.mclk(mclk), .srst(srst), .vccPor(vccPor),
      .vtrPor(vtrPor), .vbatPor(vbatPor), .cfgMode(cfgMode),
      .hostWr(hostWr), .hostRd(hostRd), .portSel(portSel),
      .hostWrData(hostWrData), .wdtStatus(wdtStatus),
      .sciEvent(sciEvent), .hostRdData(hostRdData), .ldnSel(ldnSel),
      .actAux(actAux), .actPm(actPm), .pmBase(pmBase),
      .pmIrqSel(pmIrqSel), .pmSleepWake(pmSleepWake),
      .runAccessEn(runAccessEn), .runSelIndex(runSelIndex),
      .softResetPulse(softResetPulse),
      .globalPowerControl(globalPowerControl), .wdtUnits(wdtUnits),
      .wdtVal(wdtVal), .wdtSetup(wdtSetup), .wdtCtrl(wdtCtrl),
      .wdtForce(wdtForce), .sciOut(sciOut));

   cidr_host_model i_cidr_host_model (.mclk(mclk),
      .hostRdData(hostRdData), .hostWr(hostWr), .hostRd(hostRd),
      .portSel(portSel), .hostWrData(hostWrData));

   always #50 mclk = ~mclk;

   // =========================================================
   // Expectation helpers and checking
   function automatic logic [7:0] run_loc(input logic [1:0] c);
      return c[1] ? 8'hE4 : (c[0] ? 8'hE2 : 8'hE0);
   endfunction

   task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
      checkCount++;
      if (g !== e) begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic finish_test;
      if (nFail == 0 && checkCount > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] v);
      i_cidr_host_model.wr(i, v);
   endtask

   task automatic rd_chk(input string n, input logic [7:0] i,
      input logic [7:0] e);
      i_cidr_host_model.rd(i, r);
      chk(n, {8'h00, e}, {8'h00, r});
   endtask

   task automatic pulse(input int which);
      @(posedge mclk) #1;
      if (which == 0) {srst, vccPor} = 2'b11;
      else vtrPor = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      srst = 1'b0;
      vccPor = 1'b0;
      vtrPor = 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   initial begin
      #5_000_000;
      nFail++;
      finish_test();
   end

   // =========================================================
   // Main sequence
   initial begin
      {mclk, cfgMode, wdtStatus, sciEvent} = 4'h0;
      {srst, vccPor, vtrPor, vbatPor} = 4'hF;
      nFail = 0;
      checkCount = 0;
      u = $urandom(86973);
      repeat (4) @(posedge mclk);
      #1;
      {srst, vccPor, vtrPor, vbatPor} = 4'h0;
      cfgMode = 1'b1;
      repeat (3) @(posedge mclk);
      rd_chk("runsel_rst", IDX_RUN_SEL, 8'h03);
      chk("runsel_loc", 16'h00E4, {8'h00, runSelIndex});
      rd_chk("ldn_rst", IDX_LDN, 8'h00);
      wr(IDX_LDN, LDN_AUX);
      chk("ldn_out", {8'h00, LDN_AUX}, {8'h00, ldnSel});
      foreach (batIdx[k]) rd_chk("bat_rst", batIdx[k], batVal[k]);
      for (int k = 0; k < 24; k++) begin
         u = rwIdx[$urandom_range(11)];
         d = $urandom;
         wr(u, d);
         rd_chk("rw", u, d);
      end
      foreach (nilIdx[k]) begin
         wr(nilIdx[k], $urandom);
         rd_chk("unmapped", nilIdx[k], 8'h00);
      end
      rd_chk("ctrl_wo", IDX_CFG_CTRL, 8'h00);
      d = $urandom;
      wr(IDX_PWR_CTRL, d);
      rd_chk("pwr_ctrl", IDX_PWR_CTRL, d & 8'h39);
      for (int c = 0; c < 4; c++) begin
         d = ({$urandom} & 8'h7C) | c;
         wr(IDX_RUN_SEL, d);
         u = run_loc(d[1:0]);
         chk("run_loc", {8'h00, u}, {8'h00, runSelIndex});
         rd_chk("run_sel", IDX_RUN_SEL, d & 8'h83);
      end
      wdtStatus = 1'b1;
      d = {$urandom} | 8'h01;
      wr(IDX_WATCHDOG_CONTROL, d);
      chk("wdt_force", 16'h0001, {15'h0, wdtForce});
      chk("watchdog_control", {8'h00, d & 8'hFC}, {8'h00, wdtCtrl});
      rd_chk("wdt_rd", IDX_WATCHDOG_CONTROL, d & 8'hFC | 8'h02);
      u = $urandom;
      wr(IDX_WDT_UNIT, u);
      wr(IDX_ACTIVATE, 8'h01);
      wr(IDX_LDN, LDN_PM);
      wr(IDX_ACTIVATE, 8'h00);
      chk("act_other", 16'h0002, {14'h0, actAux, actPm});
      wr(IDX_ACTIVATE, 8'h01);
      d = $urandom;
      wr(IDX_BASE_HI, d);
      wr(IDX_BASE_LO, ~d);
      chk("base_pair", {d, ~d}, pmBase);
      q = $urandom;
      wr(IDX_IRQ_SEL, q);
      wr(IDX_SLEEP_WAKE, ~q);
      chk("irq_sel", {8'h00, q}, {8'h00, pmIrqSel});
      chk("sleep_wake", {8'h00, ~q}, {8'h00, pmSleepWake});
      wr(IDX_CFG_CTRL, 8'h01);
      chk("soft_pulse", 16'h0001, {15'h0, softResetPulse});
      @(posedge mclk) #1;
      chk("soft_act", 16'h0000, {14'h0, actAux, actPm});
      chk("soft_base", 16'h0000, pmBase);
      chk("soft_keep", {8'h00, u}, {8'h00, wdtUnits});
      sciEvent = 1'b1;
      @(posedge mclk) #1;
      chk("sci_on", 16'h0001, {15'h0, sciOut});
      sciEvent = 1'b0;
      @(posedge mclk) #1;
      chk("sci_off", 16'h0000, {15'h0, sciOut});
      wr(IDX_LDN, LDN_AUX);
      cfgMode = 1'b0;
      wr(IDX_LDN, LDN_PM);
      rd_chk("glob_run", IDX_LDN, 8'h00);
      d = $urandom;
      wr(IDX_PIN_GRP1, d);
      rd_chk("run_deny", IDX_PIN_GRP1, 8'h00);
      cfgMode = 1'b1;
      rd_chk("glob_cfg", IDX_LDN, LDN_AUX);
      wr(IDX_RUN_SEL, 8'h83);
      chk("run_en", 16'h0001, {15'h0, runAccessEn});
      cfgMode = 1'b0;
      wr(IDX_PIN_GRP1, d);
      rd_chk("run_open", IDX_PIN_GRP1, d);
      cfgMode = 1'b1;
      wr(IDX_PWR_CTRL, 8'h39);
      pulse(0);
      cfgMode = 1'b1;
      rd_chk("pwr_hard", IDX_PWR_CTRL, 8'h20);
      wr(IDX_LDN, LDN_AUX);
      rd_chk("bat_keep", IDX_PIN_GRP1, d);
      pulse(1);
      rd_chk("pwr_vtr", IDX_PWR_CTRL, 8'h00);
      rd_chk("bat_vtr", IDX_PIN_GRP1, d);
      chk("irq_keep", {8'h00, q}, {8'h00, pmIrqSel});
      chk("sleep_keep", {8'h00, ~q}, {8'h00, pmSleepWake});
      finish_test();
   end
endmodule
